// File: scc_clock_ctl.sv
// System clock source select and internal oscillator control.
// Assumes register strobes and pins are synchronous to SYS_CLK.
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps

module scc_clock_ctl (
    // Clock, reset, enable
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic CE,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // Clock pins and override
    input wire logic EXT_CLK_PIN,
    input wire logic RTC_CLK_PIN,
    input wire logic EXT_OVERRIDE,
    // System clock
    output logic SYS_TICK,
    output scc_pkg::scc_src_t SRC_ACTIVE,
    output logic SWITCHING,
    // Oscillator state
    output logic OSC_POWER,
    output logic OSC_RUN,
    output logic OSC_OUT_EN
);
    import scc_pkg::*;

    // ==========================================================
    // Declarations
    scc_bus_s bus;
    scc_src_t sys_clk_source_field_r;
    scc_osc_ctl_s osc_ctl_r;
    scc_src_t target_r;
    scc_src_t target_nxt;
    logic pin_d_r;
    logic rtc_d_r;
    logic pin_rise;
    logic pin_fall;
    logic rtc_rise;
    logic pin_stop_r;
    logic osc_run_r;
    logic osc_out_r;
    logic [DIV_BITS-1:0] div_cnt_r;
    logic [NUM_SRC-1:0] src_tick;
    logic sw_tick;
    scc_src_t sw_active;
    logic sw_busy;
    logic [7:0] status;
    logic [7:0] rdata_nxt;

    assign bus = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD};

    // ==========================================================
    // Register writes
    // RULE5 upper bits dropped
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            sys_clk_source_field_r <= SRC_SEL_RESET;
        end else if (CE && bus.wr && bus.addr == ADDR_SRC_SEL) begin
            sys_clk_source_field_r <= bus.wdata[2:0];
        end
    end

    // RULE6 reset hold power
    // RULE7 bit three dropped
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            osc_ctl_r <= OSC_CTL_RESET;
        end else if (CE && bus.wr && bus.addr == ADDR_OSC_CTL) begin
            osc_ctl_r.hold <= bus.wdata[OSC_HOLD_POS];
            osc_ctl_r.power <= bus.wdata[OSC_POWER_POS];
            osc_ctl_r.pin_ctl <= bus.wdata[OSC_PIN_CTL_POS];
        end
    end

    // ==========================================================
    // Register reads
    always_comb begin
        status = READ_ZERO;
        status[STAT_SRC_LSB +: 3] = sw_active;
        status[STAT_BUSY_POS] = sw_busy;
        status[STAT_RUN_POS] = osc_run_r;
        status[STAT_OUT_POS] = osc_out_r;
        status[STAT_STOP_POS] = pin_stop_r;
    end

    // RULE5 upper bits zero
    always_comb begin
        rdata_nxt = READ_ZERO;
        if (bus.addr == ADDR_SRC_SEL) begin
            rdata_nxt[2:0] = sys_clk_source_field_r;
        end else if (bus.addr == ADDR_OSC_CTL) begin
            rdata_nxt[OSC_HOLD_POS] = osc_ctl_r.hold;
            rdata_nxt[OSC_POWER_POS] = osc_ctl_r.power;
            rdata_nxt[OSC_PIN_CTL_POS] = osc_ctl_r.pin_ctl;
        end else if (bus.addr == ADDR_STATUS) begin
            rdata_nxt = status;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            REG_RDATA <= READ_ZERO;
        end else if (CE) begin
            REG_RDATA <= bus.rd ? rdata_nxt : READ_ZERO;
        end
    end

    // ==========================================================
    // Pin edge detection
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            pin_d_r <= 1'b0;
            rtc_d_r <= 1'b0;
        end else if (CE) begin
            pin_d_r <= EXT_CLK_PIN;
            rtc_d_r <= RTC_CLK_PIN;
        end
    end

    assign pin_rise = EXT_CLK_PIN && !pin_d_r;
    assign pin_fall = !EXT_CLK_PIN && pin_d_r;
    assign rtc_rise = RTC_CLK_PIN && !rtc_d_r;

    // ==========================================================
    // Oscillator stop by pin
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            pin_stop_r <= 1'b0;
        end else if (CE) begin
            // RULE8 hold keeps running
            if (osc_ctl_r.hold || !osc_ctl_r.pin_ctl) begin
                pin_stop_r <= 1'b0;
            // RULE11 rise stops oscillator
            end else if (pin_rise) begin
                pin_stop_r <= 1'b1;
            // RULE11 fall restarts oscillator
            end else if (pin_fall) begin
                pin_stop_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Oscillator power and output gate
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            osc_run_r <= 1'b1;
            osc_out_r <= 1'b1;
        end else if (CE) begin
            // RULE10 power bit gates
            osc_run_r <= osc_ctl_r.power && !pin_stop_r;
            // RULE9 hold gates output
            osc_out_r <= osc_ctl_r.power && !pin_stop_r && osc_ctl_r.hold;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            OSC_POWER <= 1'b1;
            OSC_RUN <= 1'b1;
            OSC_OUT_EN <= 1'b1;
        end else if (CE) begin
            OSC_POWER <= osc_ctl_r.power;
            OSC_RUN <= osc_ctl_r.power && !pin_stop_r;
            OSC_OUT_EN <= osc_ctl_r.power && !pin_stop_r && osc_ctl_r.hold;
        end
    end

    // ==========================================================
    // Oscillator divider
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            div_cnt_r <= '0;
        end else if (CE && osc_run_r) begin
            div_cnt_r <= div_cnt_r + 3'h1;
        end
    end

    // RULE3 divided tick taps
    generate
        for (genvar k = 0; k < NUM_DIV; k++) begin : g_div
            localparam logic [DIV_BITS-1:0] MASK = DIV_BITS'((1 << k) - 1);
            assign src_tick[k] = osc_out_r && ((div_cnt_r & MASK) == MASK);
        end
    endgenerate

    // RULE4 pin and RTC
    assign src_tick[SRC_PIN] = pin_rise;
    assign src_tick[SRC_RTC] = rtc_rise;
    assign src_tick[NUM_SRC-1:SRC_RTC+1] = '0;

    // ==========================================================
    // Source selection
    always_comb begin
        target_nxt = target_r;
        // RULE2 override forces pin
        if (EXT_OVERRIDE) begin
            target_nxt = SRC_PIN;
        // RULE3 divider codes
        end else if (sys_clk_source_field_r <= SRC_DIV8) begin
            target_nxt = sys_clk_source_field_r;
        // RULE4 reserved codes ignored
        end else if (sys_clk_source_field_r <= SRC_RTC) begin
            target_nxt = sys_clk_source_field_r;
        end
    end

    // RULE1 reset to undivided
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            target_r <= SRC_DIV1;
        end else if (CE) begin
            target_r <= target_nxt;
        end
    end

    // ==========================================================
    // Glitch-free switch
    // RULE14 clean source change
    scc_switch u_switch (
        .clk(SYS_CLK),
        .nrst(NRST),
        .ce(CE),
        .src_tick(src_tick),
        .target(target_r),
        .tick_r(sw_tick),
        .active_r(sw_active),
        .busy_r(sw_busy)
    );

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            SYS_TICK <= 1'b0;
            SRC_ACTIVE <= SRC_DIV1;
            SWITCHING <= 1'b0;
        end else if (CE) begin
            SYS_TICK <= sw_tick;
            SRC_ACTIVE <= sw_active;
            SWITCHING <= sw_busy;
        end
    end

endmodule : scc_clock_ctl

// File: scc_pkg.sv
// Constants, types and register map of the system clock select block.
// Assumes one 20 MHz clock that stands for the internal oscillator.
// Notes on behaviour
// RULE1: After reset the internal oscillator, undivided, drives the system clock.
// RULE2: A set external override bit forces the CMOS clock pin, whatever the field holds.
// RULE3: Field codes 000 to 011 pick the oscillator divided by 1, 2, 4, 8.
// RULE4: Code 100 picks the clock pin, 101 the RTC clock; others are reserved.
// RULE5: Unused upper bits of both registers read zero and ignore writes.
// RULE6: Reset sets the hold and power bits of the oscillator control register.
// RULE7: Software writes zero to control bit 3; it always reads back zero.
// RULE8: With the hold bit set the oscillator runs regardless of the pin.
// RULE9: Clearing the hold bit gates the oscillator output but keeps it powered.
// RULE10: A clear power bit removes oscillator power; set lets it run.
// RULE11: Pin control without hold: pin rise stops oscillator, next fall restarts it.
// RULE12: Software sets hold and pin control together before clearing the hold bit.
// RULE13: Software may write all zeros to oscillator control while on the pin clock.
// RULE14: Source and divider changes never truncate or glitch a system clock period.
package scc_pkg;

    // ==========================================================
    // Clock and timing
    localparam int unsigned OSC_FREQ_MHZ = 20;
    localparam int unsigned CLK_PERIOD_NS = 1000 / OSC_FREQ_MHZ;
    localparam int unsigned DIV_BITS = 3;

    // ==========================================================
    // Register map
    localparam logic [7:0] ADDR_SRC_SEL = 8'h32;
    localparam logic [7:0] ADDR_OSC_CTL = 8'h33;
    localparam logic [7:0] ADDR_STATUS = 8'h36;
    localparam logic [2:0] SRC_SEL_RESET = 3'h0;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ==========================================================
    // Field positions
    localparam int unsigned OSC_PIN_CTL_POS = 0;
    localparam int unsigned OSC_POWER_POS = 1;
    localparam int unsigned OSC_HOLD_POS = 2;
    localparam int unsigned STAT_SRC_LSB = 0;
    localparam int unsigned STAT_BUSY_POS = 3;
    localparam int unsigned STAT_RUN_POS = 4;
    localparam int unsigned STAT_OUT_POS = 5;
    localparam int unsigned STAT_STOP_POS = 6;

    // ==========================================================
    // Source encodings
    localparam logic [2:0] SRC_DIV1 = 3'h0;
    localparam logic [2:0] SRC_DIV8 = 3'h3;
    localparam logic [2:0] SRC_PIN = 3'h4;
    localparam logic [2:0] SRC_RTC = 3'h5;
    localparam int unsigned NUM_SRC = 8;
    localparam int unsigned NUM_DIV = 4;

    // ==========================================================
    // Types
    typedef logic [2:0] scc_src_t;

    typedef struct packed {
        logic hold;
        logic power;
        logic pin_ctl;
    } scc_osc_ctl_s;

    localparam scc_osc_ctl_s OSC_CTL_RESET = '{hold: 1'b1, power: 1'b1, pin_ctl: 1'b0};

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } scc_bus_s;

    typedef enum logic [1:0] {
        SW_RUN,
        SW_DRAIN,
        SW_ARM
    } scc_sw_state_e;

endpackage : scc_pkg

// File: scc_switch.sv
// Glitch-free selector between system clock tick sources.
// Assumes each source tick is a one-cycle pulse marking a rising edge.
`timescale 1ns/100ps

module scc_switch (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // Sources and request
    input wire logic [scc_pkg::NUM_SRC-1:0] src_tick,
    input wire scc_pkg::scc_src_t target,
    // Result
    output logic tick_r,
    output scc_pkg::scc_src_t active_r,
    output logic busy_r
);
    import scc_pkg::*;

    scc_sw_state_e state_r;
    scc_src_t pend_r;

    // ==========================================================
    // Source change sequence
    // RULE14 finish then start
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_r <= SW_RUN;
            active_r <= SRC_DIV1;
            pend_r <= SRC_DIV1;
            tick_r <= 1'b0;
            busy_r <= 1'b0;
        end else if (ce) begin
            unique case (state_r)
                SW_RUN: begin
                    tick_r <= src_tick[active_r];
                    if (target != active_r) begin
                        pend_r <= target;
                        busy_r <= 1'b1;
                        state_r <= src_tick[active_r] ? SW_ARM : SW_DRAIN;
                    end
                end
                SW_DRAIN: begin
                    tick_r <= src_tick[active_r];
                    if (src_tick[active_r]) begin
                        state_r <= SW_ARM;
                    end
                end
                SW_ARM: begin
                    tick_r <= src_tick[pend_r];
                    if (src_tick[pend_r]) begin
                        active_r <= pend_r;
                        busy_r <= 1'b0;
                        state_r <= SW_RUN;
                    end
                end
            endcase
        end
    end

endmodule : scc_switch

// File: scc_clock_ctl_assertions.sv
// Checker of the clock select block, bound to its top module.
// Assumes the bench keeps CE high while timing is judged.
`timescale 1ns/100ps

module scc_clock_ctl_assertions
    import scc_pkg::*;
(
    // Clock, reset, enable
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic CE,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    // Pins and outputs
    input wire logic EXT_CLK_PIN,
    input wire logic EXT_OVERRIDE,
    input wire logic SYS_TICK,
    input wire scc_pkg::scc_src_t SRC_ACTIVE,
    input wire logic SWITCHING,
    input wire logic OSC_POWER,
    input wire logic OSC_RUN,
    input wire logic OSC_OUT_EN
);
    // ==========================================================
    // Shadow of the oscillator control bits.
    logic [2:0] ctl_r;

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            ctl_r <= 3'h6;
        end else if (CE && REG_WR && REG_ADDR == 8'h33) begin
            ctl_r <= REG_WDATA[2:0];
        end
    end

    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!NRST || !CE);

    // ==========================================================
    // Properties.
    a_sel_upper_zero: assert property (REG_RD && REG_ADDR == 8'h32 |=> REG_RDATA[7:3] == 5'h00)
        else $error("select upper bits not zero");
    a_ctl_upper_zero: assert property (REG_RD && REG_ADDR == 8'h33 |=> REG_RDATA[7:3] == 5'h00)
        else $error("control upper bits not zero");
    a_unmapped_reads_zero: assert property (REG_RD && !(REG_ADDR inside {8'h32, 8'h33, 8'h36})
        |=> REG_RDATA == 8'h00) else $error("unmapped read not zero");
    a_power_off: assert property (REG_WR && REG_ADDR == 8'h33 && !REG_WDATA[1]
        |-> ##[1:3] !OSC_POWER && !OSC_RUN) else $error("oscillator still powered");
    a_hold_gates_out: assert property (REG_WR && REG_ADDR == 8'h33 && REG_WDATA[2:1] == 2'b01
        |-> ##[1:3] !OSC_OUT_EN && OSC_POWER) else $error("gating wrong");
    a_hold_keeps_run: assert property (ctl_r == 3'h7 ##1 ctl_r == 3'h7 ##1 ctl_r == 3'h7
        |-> OSC_RUN) else $error("oscillator stopped under hold");
    a_pin_stops_osc: assert property (ctl_r == 3'h3 && $rose(EXT_CLK_PIN)
        |-> ##[1:2] !OSC_RUN) else $error("pin rise did not stop");
    a_pin_starts_osc: assert property (ctl_r == 3'h3 && $fell(EXT_CLK_PIN)
        |-> ##[1:2] OSC_RUN) else $error("pin fall did not restart");
    a_override_switch: assert property ($rose(EXT_OVERRIDE) && !SWITCHING
        && SRC_ACTIVE != SRC_PIN |-> ##[1:4] SWITCHING) else $error("override ignored");
    a_div8_gap: assert property (SYS_TICK && SRC_ACTIVE == SRC_DIV8 && !SWITCHING
        |=> !SYS_TICK [*7]) else $error("divide by eight spacing wrong");
    a_no_double_tick: assert property (SYS_TICK && !SWITCHING && SRC_ACTIVE != SRC_DIV1
        |=> !SYS_TICK) else $error("truncated system clock period");

    c_switch_done: cover property (SWITCHING ##1 !SWITCHING);
    c_pin_stop: cover property ($fell(OSC_RUN));
    c_override: cover property (EXT_OVERRIDE && SRC_ACTIVE == SRC_PIN);
endmodule : scc_clock_ctl_assertions

bind scc_clock_ctl scc_clock_ctl_assertions u_chk (.SYS_CLK(SYS_CLK), .NRST(NRST), .CE(CE),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .EXT_CLK_PIN(EXT_CLK_PIN), .EXT_OVERRIDE(EXT_OVERRIDE),
    .SYS_TICK(SYS_TICK), .SRC_ACTIVE(SRC_ACTIVE), .SWITCHING(SWITCHING),
    .OSC_POWER(OSC_POWER), .OSC_RUN(OSC_RUN), .OSC_OUT_EN(OSC_OUT_EN));

// File: scc_clock_ctl_tb.sv
// Self-checking bench of the clock select block.
// Assumes the package, design and checker are compiled first.
`timescale 1ns/100ps

module scc_clock_ctl_tb;
    import scc_pkg::*;
    logic SYS_CLK = 1'b0;
    logic NRST = 1'b0;
    logic CE = 1'b1;
    logic [7:0] REG_ADDR = 8'h00;
    logic [7:0] REG_WDATA = 8'h00;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic EXT_CLK_PIN = 1'b0;
    logic RTC_CLK_PIN = 1'b0;
    logic EXT_OVERRIDE = 1'b0;
    logic pin_auto = 1'b1;
    logic pin_man = 1'b0;
    logic [7:0] REG_RDATA;
    logic SYS_TICK, SWITCHING, OSC_POWER, OSC_RUN, OSC_OUT_EN;
    scc_src_t SRC_ACTIVE;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n;

    scc_clock_ctl dut (.SYS_CLK(SYS_CLK), .NRST(NRST), .CE(CE), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .EXT_CLK_PIN(EXT_CLK_PIN), .RTC_CLK_PIN(RTC_CLK_PIN), .EXT_OVERRIDE(EXT_OVERRIDE),
        .SYS_TICK(SYS_TICK), .SRC_ACTIVE(SRC_ACTIVE), .SWITCHING(SWITCHING),
        .OSC_POWER(OSC_POWER), .OSC_RUN(OSC_RUN), .OSC_OUT_EN(OSC_OUT_EN));

    always #25 SYS_CLK = ~SYS_CLK;

    // ==========================================================
    // Pin clocks and the run limit.
    always @(posedge SYS_CLK) begin
        cyc <= cyc + 1;
        RTC_CLK_PIN <= (cyc % 10) < 5;
        EXT_CLK_PIN <= pin_auto ? ((cyc % 6) < 3) : pin_man;
        if (cyc == 20000) begin
            err_total++;
            end_of_test();
        end
    end

    // ==========================================================
    // Shared tasks.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge SYS_CLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge SYS_CLK);
        REG_WR <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge SYS_CLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge SYS_CLK);
        REG_RD <= 1'b0;
        #1 check(REG_RDATA, exp);
    endtask : rd

    task automatic step(input int k);
        repeat (k) @(posedge SYS_CLK);
        #1;
    endtask : step

    task automatic osc(input logic [2:0] exp);
        check({5'h00, OSC_POWER, OSC_RUN, OSC_OUT_EN}, {5'h00, exp});
    endtask : osc

    task automatic sel(input logic [2:0] code, input logic [2:0] act, input int per);
        wr(8'h32, {5'h00, code});
        step(4);
        n = 0;
        while (SWITCHING !== 1'b0 && n < 200) begin
            step(1);
            n++;
        end
        check({5'h00, SRC_ACTIVE}, {5'h00, act});
        n = 0;
        while (SYS_TICK !== 1'b1 && n < 40) begin
            step(1);
            n++;
        end
        n = 0;
        do begin
            step(1);
            n++;
        end while (SYS_TICK !== 1'b1 && n < 40);
        check(8'(n), 8'(per));
    endtask : sel

    task automatic pin(input logic v);
        @(posedge SYS_CLK);
        pin_man <= v;
        step(4);
    endtask : pin

    // ==========================================================
    // Scenarios.
    task automatic t_reset();
        step(3);
        check({7'h00, SYS_TICK}, 8'h01);
        step(1);
        check({7'h00, SYS_TICK}, 8'h01);
        check({5'h00, SRC_ACTIVE}, 8'h00);
        osc(3'h7);
        rd(8'h32, 8'h00);
        rd(8'h33, 8'h06);
        rd(8'h36, 8'h30);
    endtask : t_reset

    task automatic t_regs();
        wr(8'h32, 8'hF8);
        rd(8'h32, 8'h00);
        wr(8'h33, 8'hF6);
        rd(8'h33, 8'h06);
        rd(8'h35, 8'h00);
    endtask : t_regs

    task automatic t_sel();
        for (int i = 0; i < 4; i++) begin
            sel(i[2:0], i[2:0], 1 << i);
        end
        sel(3'h4, 3'h4, 6);
        sel(3'h5, 3'h5, 10);
        wr(8'h32, 8'h06);
        step(8);
        check({5'h00, SRC_ACTIVE}, 8'h05);
        rd(8'h32, 8'h06);
        sel(3'h0, 3'h0, 1);
        @(posedge SYS_CLK);
        EXT_OVERRIDE <= 1'b1;
        step(30);
        check({5'h00, SRC_ACTIVE}, 8'h04);
        @(posedge SYS_CLK);
        EXT_OVERRIDE <= 1'b0;
        step(30);
        check({5'h00, SRC_ACTIVE}, 8'h00);
    endtask : t_sel

    task automatic t_osc();
        sel(3'h4, 3'h4, 6);
        @(posedge SYS_CLK);
        pin_man <= 1'b0;
        pin_auto <= 1'b0;
        wr(8'h33, 8'h07);
        pin(1'b1);
        osc(3'h7);
        pin(1'b0);
        wr(8'h33, 8'h03);
        step(3);
        osc(3'h6);
        pin(1'b1);
        osc(3'h4);
        pin(1'b0);
        osc(3'h6);
        wr(8'h33, 8'h00);
        step(3);
        osc(3'h0);
        wr(8'h33, 8'h06);
        @(posedge SYS_CLK);
        pin_auto <= 1'b1;
        step(4);
        osc(3'h7);
        sel(3'h0, 3'h0, 1);
    endtask : t_osc

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (4) @(posedge SYS_CLK);
        NRST <= 1'b1;
        t_reset();
        t_regs();
        t_sel();
        t_osc();
        end_of_test();
    end
endmodule : scc_clock_ctl_tb
